// >>> include/asr_defines.svh
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ASR_OFS_CONTROL 5'h00
`define ASR_OFS_BAUD 5'h04
`define ASR_OFS_DATA 5'h08
`define ASR_OFS_STATUS 5'h0c
`define ASR_OFS_IRQ_ENABLE 5'h10
`define ASR_OFS_IRQ_CLEAR 5'h14

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ASR_CTL_ENABLE 0
`define ASR_CTL_NINE_BIT 1

// ----------------------------------------------------------------------
// Status, enable and clear register fields
// ----------------------------------------------------------------------
`define ASR_ST_RX_FULL 0
`define ASR_ST_FRAMING 1
`define ASR_ST_NOISE 2
`define ASR_ST_OVERRUN 3
`define ASR_ST_BREAK 4
`define ASR_ST_WIDTH 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ASR_BAUD_RESET 16'h0000
`define ASR_STATUS_RESET 5'h00

// ----------------------------------------------------------------------
// Oversample tick points within one bit
// ----------------------------------------------------------------------
`define ASR_RT_FIRST 5'h01
`define ASR_RT_VERIFY_A 5'h03
`define ASR_RT_VERIFY_B 5'h05
`define ASR_RT_VERIFY_C 5'h07
`define ASR_RT_MAJ_A 5'h08
`define ASR_RT_MAJ_B 5'h09
`define ASR_RT_MAJ_C 5'h0a
`define ASR_RT_LAST 5'h10

`endif

// >>> include/asr_pkg.sv
package asr_pkg;

   typedef enum logic [1:0] {
      asr_search,
      asr_start,
      asr_data,
      asr_stop
   } asr_rx_state_type;

endpackage : asr_pkg

// >>> core/asr_tick_gen.sv
`timescale 1ns/1ns
`default_nettype none

module asr_tick_gen (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic enable,
   input wire logic [15:0] divisor,
   output logic tick
);

   typedef struct packed {
      logic [15:0] count;
      logic tick;
   } asr_tick_state_type;

   asr_tick_state_type s;
   asr_tick_state_type next_s;

   // One tick every divisor+1 clocks; a divisor of zero ticks every clock.
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      if (!enable) begin
         next_s.count = 16'h0000;
      end else if (s.count >= divisor) begin
         next_s.count = 16'h0000;
         next_s.tick = 1'b1;
      end else begin
         next_s.count = s.count + 16'h0001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign tick = s.tick;

endmodule : asr_tick_gen

`default_nettype wire

// >>> core/asr_receiver.sv
`timescale 1ns/1ns
`default_nettype none
`include "asr_defines.svh"

module asr_receiver (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic rx_line,
   output logic rx_irq
);

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   typedef struct packed {
      asr_pkg::asr_rx_state_type state;
      logic [4:0] rt;
      logic [2:0] hist;
      logic [2:0] samp;
      logic last_s;
      logic prev_bit;
      logic [3:0] bitidx;
      logic [8:0] shreg;
      logic noise_acc;
      logic enable;
      logic nine;
      logic [15:0] baud;
      logic [7:0] data;
      logic ninth_rx_bit;
      logic [4:0] status;
      logic [4:0] irq_en;
      logic irq;
      logic [31:0] rdata;
      logic dp_write;
      logic [4:0] dp_addr;
      logic ready;
      logic resp;
   } asr_state_type;

   asr_state_type s;
   asr_state_type next_s;
   logic tick;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [1:0] ones3(input logic [2:0] v);
      ones3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
   endfunction : ones3

   function automatic logic maj3(input logic [2:0] v);
      maj3 = (ones3(v) >= 2'd2);
   endfunction : maj3

   function automatic logic mixed3(input logic [2:0] v);
      mixed3 = (v != 3'b000) && (v != 3'b111);
   endfunction : mixed3

   // Index of the last data bit for the selected character length.
   function automatic logic [3:0] last_bit(input logic nine);
      last_bit = nine ? 4'h8 : 4'h7;
   endfunction : last_bit

   // The tick divider is the only baud source; its divisor is software's.
   asr_tick_gen asr_tick_gen_i (
      .hclk(hclk),
      .hresetn(hresetn),
      .enable(s.enable),
      .divisor(s.baud),
      .tick(tick)
   );

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   logic [4:0] ev;
   logic [4:0] clr;
   logic [2:0] trio;
   logic m;
   logic fe;
   logic brk;
   logic [8:0] dmask;
   logic addr_ok;
   logic [4:0] aw;

   always_comb begin
      next_s = s;
      ev = '0;
      clr = '0;
      trio = {s.samp[1:0], rx_line};
      m = maj3(trio);
      fe = 1'b0;
      brk = 1'b0;
      dmask = s.nine ? 9'h1ff : 9'h0ff;
      addr_ok = hsel && htrans[1] && hready;
      aw = {haddr[4:2], 2'b00};

      // Receive machine, advanced only on oversample ticks.
      if (!s.enable) begin
         next_s.state = asr_pkg::asr_search;
         next_s.hist = 3'b000;
      end else if (tick) begin
         next_s.last_s = rx_line;
         next_s.rt = s.rt + 5'h01;
         case (s.state)
            asr_pkg::asr_search: begin
               next_s.hist = {s.hist[1:0], rx_line};
               if (s.hist == 3'b111 && !rx_line) begin
                  next_s.state = asr_pkg::asr_start;
                  next_s.rt = `ASR_RT_FIRST + 5'h01;
                  next_s.noise_acc = 1'b0;
               end
            end
            asr_pkg::asr_start: begin
               if (s.rt == `ASR_RT_VERIFY_A || s.rt == `ASR_RT_VERIFY_B ||
                   s.rt == `ASR_RT_MAJ_A || s.rt == `ASR_RT_MAJ_B) begin
                  next_s.samp = trio;
               end
               if (s.rt == `ASR_RT_VERIFY_C) begin
                  if (ones3(trio) >= 2'd2) begin
                     next_s.state = asr_pkg::asr_search;
                     next_s.hist = 3'b000;
                     next_s.rt = 5'h00;
                  end else if (ones3(trio) == 2'd1) begin
                     next_s.noise_acc = 1'b1;
                  end
               end
               if ((s.rt == `ASR_RT_MAJ_A || s.rt == `ASR_RT_MAJ_B ||
                    s.rt == `ASR_RT_MAJ_C) && rx_line) begin
                  next_s.noise_acc = 1'b1;
               end
               if (s.rt == `ASR_RT_LAST) begin
                  next_s.state = asr_pkg::asr_data;
                  next_s.rt = `ASR_RT_FIRST;
                  next_s.bitidx = 4'h0;
                  next_s.prev_bit = 1'b0;
               end
            end
            asr_pkg::asr_data, asr_pkg::asr_stop: begin
               if (s.rt == `ASR_RT_MAJ_A || s.rt == `ASR_RT_MAJ_B) begin
                  next_s.samp = trio;
               end
               if (s.rt == `ASR_RT_MAJ_C) begin
                  if (mixed3(trio)) begin
                     next_s.noise_acc = 1'b1;
                  end
                  if (s.state == asr_pkg::asr_data) begin
                     next_s.shreg[s.bitidx] = m;
                     next_s.prev_bit = m;
                  end else begin
                     // Stop bit decision closes the character.
                     fe = !m;
                     brk = fe && ((s.shreg & dmask) == 9'h000);
                     next_s.state = asr_pkg::asr_search;
                     next_s.hist = {m, m, m};
                     if (s.status[`ASR_ST_RX_FULL]) begin
                        ev[`ASR_ST_OVERRUN] = 1'b1;
                     end else begin
                        ev[`ASR_ST_RX_FULL] = 1'b1;
                        next_s.data = brk ? 8'h00 : s.shreg[7:0];
                        next_s.ninth_rx_bit = brk ? 1'b0 :
                           (s.nine ? s.shreg[8] : s.shreg[7]);
                     end
                     ev[`ASR_ST_FRAMING] = fe;
                     ev[`ASR_ST_BREAK] = brk;
                     ev[`ASR_ST_NOISE] = next_s.noise_acc;
                  end
               end
               if (s.state == asr_pkg::asr_data) begin
                  if (s.rt == `ASR_RT_LAST) begin
                     next_s.rt = `ASR_RT_FIRST;
                     next_s.bitidx = s.bitidx + 4'h1;
                     if (s.bitidx == last_bit(s.nine)) begin
                        next_s.state = asr_pkg::asr_stop;
                     end
                  end
                  // A falling edge after a decided 1 marks a bit boundary.
                  if (s.prev_bit && s.last_s && !rx_line) begin
                     if (s.rt > `ASR_RT_MAJ_C) begin
                        next_s.rt = `ASR_RT_FIRST + 5'h01;
                        next_s.bitidx = s.bitidx + 4'h1;
                        if (s.bitidx == last_bit(s.nine)) begin
                           next_s.state = asr_pkg::asr_stop;
                        end
                     end else if (s.rt < `ASR_RT_MAJ_A) begin
                        next_s.rt = `ASR_RT_FIRST + 5'h01;
                     end
                  end
               end
            end
            default: begin
               next_s.state = asr_pkg::asr_search;
            end
         endcase
      end

      // Bus address phase: read data is prepared now for the data phase.
      next_s.ready = 1'b1;
      next_s.dp_write = addr_ok && hwrite;
      next_s.dp_addr = aw;
      if (addr_ok && !hwrite) begin
         case (aw)
            `ASR_OFS_CONTROL: begin
               next_s.rdata = {30'h0, s.nine, s.enable};
            end
            `ASR_OFS_BAUD: begin
               next_s.rdata = {16'h0, s.baud};
            end
            `ASR_OFS_DATA: begin
               // The buffer is freed in the address phase of its read, so a
               // character ending in that very cycle still counts as overrun.
               next_s.rdata = {23'h0, s.ninth_rx_bit, s.data};
               clr[`ASR_ST_RX_FULL] = 1'b1;
            end
            `ASR_OFS_STATUS: begin
               next_s.rdata = {27'h0, s.status};
            end
            `ASR_OFS_IRQ_ENABLE: begin
               next_s.rdata = {27'h0, s.irq_en};
            end
            default: begin
               next_s.rdata = 32'h0000_0000;
            end
         endcase
      end else begin
         next_s.rdata = 32'h0000_0000;
      end

      // Bus data phase writes; the data buffer ignores writes.
      if (s.dp_write) begin
         case (s.dp_addr)
            `ASR_OFS_CONTROL: begin
               next_s.enable = hwdata[`ASR_CTL_ENABLE];
               next_s.nine = hwdata[`ASR_CTL_NINE_BIT];
            end
            `ASR_OFS_BAUD: begin
               next_s.baud = hwdata[15:0];
            end
            `ASR_OFS_IRQ_ENABLE: begin
               next_s.irq_en = hwdata[4:0];
            end
            `ASR_OFS_IRQ_CLEAR: begin
               clr = clr | hwdata[4:0];
            end
            default: begin
               next_s.baud = s.baud;
            end
         endcase
      end

      // A new event in the clearing cycle survives the clear.
      next_s.status = (s.status & ~clr) | ev;
      next_s.irq = |(next_s.status & next_s.irq_en);
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.state <= asr_pkg::asr_search;
         s.baud <= `ASR_BAUD_RESET;
         s.status <= `ASR_STATUS_RESET;
         s.ready <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata = s.rdata;
   assign hreadyout = s.ready;
   assign hresp = s.resp;
   assign rx_irq = s.irq;

endmodule : asr_receiver

`default_nettype wire

// >>> tb/asr_rx_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module asr_rx_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic rx_line,
   input wire logic rx_irq
);
   logic ph;
   logic rd;
   logic wrote;
   logic [7:0] hi;

   default clocking @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_take;
      hsel && htrans[1] && hready;
   endsequence
   sequence s_wr;
      s_take ##0 hwrite;
   endsequence

   // The high-run counter saturates so a long idle line cannot wrap.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph <= 1'b0;
         rd <= 1'b0;
         wrote <= 1'b0;
         hi <= 8'h00;
      end else begin
         ph <= hsel & htrans[1] & hready;
         rd <= hsel & htrans[1] & hready & !hwrite;
         wrote <= wrote | (hsel & htrans[1] & hready & hwrite);
         hi <= !rx_line ? 8'h00 : (hi == 8'hff ? hi : hi + 8'h01);
      end
   end

   chk_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   chk_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   chk_rdata_idle: assert property (!rd |-> hrdata == 32'h0)
      else $error("hrdata outside read phase");
   chk_write_quiet: assert property (s_wr |=> hrdata == 32'h0)
      else $error("hrdata during write");
   chk_upper_zero: assert property (rd |-> hrdata[31:16] == 16'h0)
      else $error("upper read bits set");
   chk_irq_masked: assert property (!wrote |-> !rx_irq)
      else $error("interrupt before any enable");
   chk_irq_fall: assert property ($fell(rx_irq) |-> ph || $past(ph))
      else $error("interrupt fell without access");
   chk_irq_cause: assert property (($rose(rx_irq) && !$past(ph)) |->
      hi < 8'hc8)
      else $error("interrupt on idle line");
endmodule : asr_rx_asserts

`default_nettype wire

// >>> tb/asr_serial_tx.sv
`timescale 1ns/1ns
`default_nettype none

module asr_serial_tx (
   input wire logic hclk,
   output logic rx_line
);
   initial rx_line = 1'b1;

   // Bit index 0 is start, nb+1 is stop; one flip at (gb, gp) fakes noise.
   task automatic send(input logic [8:0] d, input int nb, bc, gb, gp,
                       input logic stop);
      logic v;
      repeat (4) @(posedge hclk) rx_line <= 1'b1;
      for (int i = 0; i < nb + 2; i++) begin
         v = (i == 0) ? 1'b0 : (i == nb + 1) ? stop : d[i-1];
         for (int k = 0; k < bc; k++) begin
            @(posedge hclk);
            rx_line <= v ^ (i == gb && k == gp);
         end
      end
      @(posedge hclk) rx_line <= 1'b1;
   endtask : send

   task automatic pulse(input int n);
      repeat (4) @(posedge hclk) rx_line <= 1'b1;
      repeat (n) @(posedge hclk) rx_line <= 1'b0;
      repeat (20) @(posedge hclk) rx_line <= 1'b1;
   endtask : pulse
endmodule : asr_serial_tx

`default_nettype wire

// >>> tb/asr_receiver_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "asr_defines.svh"

`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      $display("Error at %0t: got %h expected %h", $time, g, e); \
      miscompares++; \
   end \
end

module asr_receiver_tb_top;
   localparam logic [31:0] CT = `ASR_OFS_CONTROL;
   localparam logic [31:0] BD = `ASR_OFS_BAUD;
   localparam logic [31:0] ST = `ASR_OFS_STATUS;
   localparam logic [31:0] DT = `ASR_OFS_DATA;
   localparam logic [31:0] IE = `ASR_OFS_IRQ_ENABLE;
   localparam logic [31:0] IC = `ASR_OFS_IRQ_CLEAR;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic [31:0] rdq;
   logic hreadyout;
   logic rdy;
   logic hresp;
   logic rx_line;
   logic rx_irq;
   int miscompares = 0;
   int checks_done = 0;

   always #5 hclk = ~hclk;
   always @(posedge hclk) rdq <= hrdata;
   always @(posedge hclk) rdy <= hreadyout;

   asr_receiver asr_receiver_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_line(rx_line), .rx_irq(rx_irq));
   asr_serial_tx asr_serial_tx_i (.hclk(hclk), .rx_line(rx_line));

   task automatic bus(input logic w, input logic [31:0] a, d,
                      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      do begin @(posedge hclk); #1; end while (rdy !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge hclk); #1; end while (rdy !== 1'b1);
      q = rdq;
   endtask : bus

   task automatic wr(input logic [31:0] a, d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      @(posedge hclk);
      #1;
   endtask : wr

   task automatic chk_rd(input logic [31:0] a, e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask : chk_rd

   task automatic tx(input logic [8:0] d, input int bc, gb, gp,
                     input logic stop);
      asr_serial_tx_i.send(d, 8, bc, gb, gp, stop);
   endtask : tx

   task automatic t_basic;
      tx(9'h0a5, 16, -1, 0, 1'b1);
      `CHK(rx_irq, 1'b1)
      wr(IE, 32'h0);
      `CHK(rx_irq, 1'b0)
      wr(IE, 32'h1);
      chk_rd(ST, 32'h1);
      wr(DT, 32'h0);
      chk_rd(DT, 32'h1a5);
      chk_rd(ST, 32'h0);
      `CHK(rx_irq, 1'b0)
      tx(9'h03c, 16, -1, 0, 1'b1);
      wr(IC, 32'h1);
      `CHK(rx_irq, 1'b0)
      wr(CT, 32'h3);
      asr_serial_tx_i.send(9'h15a, 9, 16, -1, 0, 1'b1);
      chk_rd(DT, 32'h15a);
      wr(CT, 32'h1);
      $display("basic and interrupt test done");
   endtask : t_basic

   // Start samples at 3/5/7 and 8-10, a data bit and the stop bit.
   task automatic t_noise;
      int gb[4] = '{0, 0, 5, 9};
      int gp[4] = '{4, 8, 8, 8};
      for (int i = 0; i < 4; i++) begin
         tx(9'h0a5, 16, gb[i], gp[i], 1'b1);
         chk_rd(ST, 32'h5);
         chk_rd(DT, 32'h1a5);
         wr(IC, 32'h1f);
      end
      $display("noise test done");
   endtask : t_noise

   task automatic t_frame;
      tx(9'h0a5, 16, -1, 0, 1'b0);
      chk_rd(ST, 32'h3);
      chk_rd(DT, 32'h1a5);
      wr(IC, 32'h1f);
      tx(9'h0ff, 16, -1, 0, 1'b1);
      tx(9'h000, 16, -1, 0, 1'b0);
      chk_rd(ST, 32'h1b);
      chk_rd(DT, 32'h1ff);
      wr(IC, 32'h1f);
      tx(9'h000, 16, -1, 0, 1'b0);
      chk_rd(ST, 32'h13);
      chk_rd(DT, 32'h0);
      wr(IC, 32'h1f);
      $display("framing, break and overrun test done");
   endtask : t_frame

   task automatic t_sync;
      asr_serial_tx_i.pulse(2);
      chk_rd(ST, 32'h0);
      tx(9'h03c, 16, -1, 0, 1'b1);
      chk_rd(ST, 32'h1);
      chk_rd(DT, 32'h03c);
      // Without resync on falling edges both rates miss the stop bit.
      for (int bc = 14; bc <= 18; bc += 4) begin
         tx(9'h055, bc, -1, 0, 1'b1);
         chk_rd(ST, 32'h1);
         chk_rd(DT, 32'h055);
      end
      $display("start search and resync test done");
   endtask : t_sync

   // Halved tick rate: a bit now lasts 32 clocks; registers read back.
   task automatic t_rate;
      chk_rd(CT, 32'h1);
      chk_rd(IE, 32'h1);
      wr(BD, 32'h1);
      chk_rd(BD, 32'h1);
      tx(9'h0c3, 32, -1, 0, 1'b1);
      chk_rd(ST, 32'h1);
      chk_rd(DT, 32'h1c3);
      wr(BD, 32'h0);
      $display("tick rate test done");
   endtask : t_rate

   task print_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : print_verdict

   initial begin
      #100000;
      miscompares++;
      print_verdict;
   end

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1;
      wr(BD, 32'h0);
      wr(CT, 32'h1);
      wr(IE, 32'h1);
      t_basic;
      t_noise;
      t_frame;
      t_sync;
      t_rate;
      print_verdict;
   end
endmodule : asr_receiver_tb_top

bind asr_receiver asr_rx_asserts asr_rx_asserts_i (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .rx_line(rx_line), .rx_irq(rx_irq));

`default_nettype wire
